//--- hw/boundary_scan_pattern_engine.v
// boundary-scan TAP with built-in pattern and signature engine
`timescale 1ns/1ns
`include "bscan_engine_consts.vh"

// Operation
// R1: random pattern steps on TCK rise, shadow and pins follow on fall
// R2: 36-bit random pattern is one LFSR across all data boundary cells
// R3: host should scan a seed into the boundary chain before running
// R4: an all-zero LFSR stays all zero, no new patterns
// R5: 36-bit signature compresses input-mode pins on each TCK rise
// R6: 36-bit signature mode holds shadow latches and keeps driving pins
// R7: 18-bit signature on inputs plus 18-bit random pattern on outputs
// R8: 18-bit signature on inputs plus 18-bit up-count on outputs
// R9: feedback arrangement mirrors with transfer direction
// R10: all test state changes only on TCK edges; run_en_reg changes on register-port writes instead
// R11: TDI, TMS and pin inputs sampled on TCK rise
// R12: TDO and pin outputs change only on TCK fall; pin enables also release after a TCK rise in Test-Logic-Reset
// R13: host changes TMS on TCK fall, rise advances TAP
// R14: serial data moves only in Shift-IR or Shift-DR
// R15: host leaves Test-Logic-Reset with TMS low
// R16: one IR scan, one DR scan, back to reset, all paced by TCK
// R17: operation decoded from control register bits 2 to 0
// R18: pattern operations run only under run instruction in Run-Test/Idle
// R19: mixed or split direction behaves as bypass
// R20: control cells 47-36 excluded, OE cells 47-44 gate the drivers
// R21: tap positions are parameters of the module, cell order is fixed by the header defines
// R22: count mode adds one per TCK rise, wraps to zero
module boundary_scan_pattern_engine #(
	parameter [35:0] TAPS36 = `TAPS36,
	parameter [17:0] TAPS18 = `TAPS18
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// test access port
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdo_oe_n,
	// a-side pins
	input wire [17:0] a_pin_in,
	output reg [17:0] a_pin_out,
	output reg [17:0] a_pin_oe_n,
	// b-side pins
	input wire [17:0] b_pin_in,
	output reg [17:0] b_pin_out,
	output reg [17:0] b_pin_oe_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata
);

	// tap states
	localparam [3:0] S_TLR = 4'hF;
	localparam [3:0] S_RTI = 4'hC;
	localparam [3:0] S_SELDR = 4'h7;
	localparam [3:0] S_CAPDR = 4'h6;
	localparam [3:0] S_SHDR = 4'h2;
	localparam [3:0] S_EX1DR = 4'h1;
	localparam [3:0] S_PSDR = 4'h3;
	localparam [3:0] S_EX2DR = 4'h0;
	localparam [3:0] S_UPDR = 4'h5;
	localparam [3:0] S_SELIR = 4'h4;
	localparam [3:0] S_CAPIR = 4'hE;
	localparam [3:0] S_SHIR = 4'hA;
	localparam [3:0] S_EX1IR = 4'h9;
	localparam [3:0] S_PSIR = 4'hB;
	localparam [3:0] S_EX2IR = 4'h8;
	localparam [3:0] S_UPIR = 4'hD;

	// operation codes, low two bits of the control register
	localparam [1:0] OP_TOGGLE = 2'h0;
	localparam [1:0] OP_RAND36 = 2'h1;
	localparam [1:0] OP_SIG36 = 2'h2;
	localparam [1:0] OP_SIG18 = 2'h3;

	// tap controller next state
	function [3:0] tap_step;
		input [3:0] s;
		input m;
		begin
			case (s)
			S_TLR: tap_step = m ? S_TLR : S_RTI;
			S_RTI: tap_step = m ? S_SELDR : S_RTI;
			S_SELDR: tap_step = m ? S_SELIR : S_CAPDR;
			S_CAPDR: tap_step = m ? S_EX1DR : S_SHDR;
			S_SHDR: tap_step = m ? S_EX1DR : S_SHDR;
			S_EX1DR: tap_step = m ? S_UPDR : S_PSDR;
			S_PSDR: tap_step = m ? S_EX2DR : S_PSDR;
			S_EX2DR: tap_step = m ? S_UPDR : S_SHDR;
			S_UPDR: tap_step = m ? S_SELDR : S_RTI;
			S_SELIR: tap_step = m ? S_TLR : S_CAPIR;
			S_CAPIR: tap_step = m ? S_EX1IR : S_SHIR;
			S_SHIR: tap_step = m ? S_EX1IR : S_SHIR;
			S_EX1IR: tap_step = m ? S_UPIR : S_PSIR;
			S_PSIR: tap_step = m ? S_EX2IR : S_PSIR;
			S_EX2IR: tap_step = m ? S_UPIR : S_SHIR;
			S_UPIR: tap_step = m ? S_SELDR : S_RTI;
			default: tap_step = S_TLR;
			endcase
		end
	endfunction

	// 36-bit lfsr step; xor feedback keeps all zeros locked at zero
	function [35:0] lfsr36;
		input [35:0] s;
		input up;
		reg fb;
		begin
			fb = ^(s & TAPS36); // R21
			lfsr36 = up ? {s[34:0], fb} : {fb, s[35:1]}; // R9
		end
	endfunction

	// 18-bit lfsr step, mirrored with direction
	function [17:0] lfsr18;
		input [17:0] s;
		input up;
		reg fb;
		begin
			fb = ^(s & TAPS18); // R21
			lfsr18 = up ? {s[16:0], fb} : {fb, s[17:1]}; // R9
		end
	endfunction

	// synchronisers: first stage read only by the second
	reg [2:0] tck_sync_reg;
	reg [1:0] tms_sync_reg;
	reg [1:0] tdi_sync_reg;
	reg [17:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
	wire tck_rise, tck_fall;

	// test state
	reg [3:0] tap_reg;
	reg [7:0] ir_reg, ir_shift_reg;
	reg bypass_reg;
	reg [2:0] test_ctl_reg, test_ctl_shift_reg;
	reg [47:0] chain_reg, shadow_reg;
	reg run_en_reg;

	// combinational
	reg [35:0] step_next;
	reg [17:0] out_half, in_half, pins_in, new_out, new_in;
	wire sel_chain, sel_ctl, dir_ok, a_to_b, running, test_drive;
	wire [1:0] op;

	// two-flop sampling of tms, tdi and the pins, three flops for tck
	always @(posedge clk_sys) begin
		tck_sync_reg <= {tck_sync_reg[1:0], tck};
		tms_sync_reg <= {tms_sync_reg[0], tms};
		tdi_sync_reg <= {tdi_sync_reg[0], tdi};
		a_s1_reg <= a_pin_in;
		a_s2_reg <= a_s1_reg;
		b_s1_reg <= b_pin_in;
		b_s2_reg <= b_s1_reg;
	end

	// edge detect on stages two and three only
	assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2]; // R10
	assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2]; // R10

	// instruction decode
	assign sel_chain = (ir_reg == `IR_BOUNDARY_SCAN) ||
		(ir_reg == `IR_BOUNDARY_READ);
	assign sel_ctl = (ir_reg == `IR_CTRL_SCAN_N) ||
		(ir_reg == `IR_CTRL_SCAN_T);

	// direction from the output-enable shadow cells
	assign dir_ok = (shadow_reg[`CELL_OE1_AB] != shadow_reg[`CELL_OE1_BA]) &&
		(shadow_reg[`CELL_OE2_AB] != shadow_reg[`CELL_OE2_BA]) &&
		(shadow_reg[`CELL_OE1_AB] == shadow_reg[`CELL_OE2_AB]); // R19
	assign a_to_b = ~shadow_reg[`CELL_OE1_AB];
	assign op = test_ctl_reg[1:0]; // R17
	assign running = (tap_reg == S_RTI) && run_en_reg && dir_ok &&
		(ir_reg == `IR_BOUNDARY_RUN); // R18
	// a bad direction under the run instruction falls back to bypass
	assign test_drive = (ir_reg == `IR_BOUNDARY_SCAN) ||
		((ir_reg == `IR_BOUNDARY_RUN) && dir_ok); // R19

	// one pattern step; control cells 47-36 never take part
	always @* begin
		out_half = a_to_b ? chain_reg[35:18] : chain_reg[17:0];
		in_half = a_to_b ? chain_reg[17:0] : chain_reg[35:18];
		pins_in = a_to_b ? a_s2_reg : b_s2_reg; // R11
		new_in = in_half;
		new_out = out_half;
		case (op)
		OP_TOGGLE: begin
			new_in = pins_in;
			new_out = ~out_half;
		end
		OP_SIG18: begin
			new_in = lfsr18(in_half, a_to_b) ^ pins_in; // R7 R8
			if (test_ctl_reg[2])
				new_out = out_half + 18'h00001; // R8 R22
			else
				new_out = lfsr18(out_half, a_to_b); // R7 R4
		end
		default: ;
		endcase
		if (op == OP_RAND36)
			step_next = lfsr36(chain_reg[35:0], a_to_b); // R2 R4
		else if (op == OP_SIG36)
			step_next = lfsr36(chain_reg[35:0], a_to_b) ^
				(a_to_b ? {18'h00000, pins_in} :
				{pins_in, 18'h00000}); // R5
		else
			step_next = a_to_b ? {new_out, new_in} : {new_in, new_out};
	end

	// tap, scan registers and pattern engine, all on tck edges
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			tap_reg <= S_TLR;
			ir_reg <= `IR_BYPASS;
			ir_shift_reg <= 8'h00;
			bypass_reg <= 1'b0;
			test_ctl_reg <= `TCTL_RESET;
			test_ctl_shift_reg <= 3'h0;
			chain_reg <= 48'h000000000000;
			shadow_reg <= 48'hF00000000000;
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			if (tck_rise) begin
				tap_reg <= tap_step(tap_reg, tms_sync_reg[1]); // R11 R13
				case (tap_reg)
				S_TLR: ir_reg <= `IR_BYPASS;
				S_CAPIR: ir_shift_reg <= `IR_CAPTURE;
				S_SHIR: ir_shift_reg <= {tdi_sync_reg[1],
					ir_shift_reg[7:1]}; // R14
				S_CAPDR: begin
					bypass_reg <= 1'b0;
					if (ir_reg == `IR_BOUNDARY_SCAN)
						chain_reg[35:0] <= {b_s2_reg, a_s2_reg};
					if (sel_ctl)
						test_ctl_shift_reg <= test_ctl_reg;
				end
				S_SHDR: begin
					if (sel_chain)
						chain_reg <= {tdi_sync_reg[1],
							chain_reg[47:1]}; // R14
					else if (sel_ctl)
						test_ctl_shift_reg <= {tdi_sync_reg[1],
							test_ctl_shift_reg[2:1]}; // R14
					else
						bypass_reg <= tdi_sync_reg[1]; // R14
				end
				S_RTI: if (running)
					chain_reg[35:0] <= step_next; // R1 R5
				default: ;
				endcase
			end
			if (tck_fall) begin
				// tdo only moves on the falling edge
				if (tap_reg == S_SHIR) begin
					tdo <= ir_shift_reg[0]; // R12 R14
					tdo_oe_n <= 1'b0;
				end else if (tap_reg == S_SHDR) begin
					tdo <= sel_chain ? chain_reg[0] :
						sel_ctl ? test_ctl_shift_reg[0] : bypass_reg; // R12
					tdo_oe_n <= 1'b0;
				end else
					tdo_oe_n <= 1'b1; // R14
				case (tap_reg)
				S_UPIR: ir_reg <= ir_shift_reg; // R16
				S_UPDR: begin
					if (ir_reg == `IR_BOUNDARY_SCAN)
						shadow_reg <= chain_reg;
					if (sel_ctl)
						test_ctl_reg <= test_ctl_shift_reg;
				end
				// shadow of output cells follows, except in 36-bit signature
				S_RTI: if (running && (op != OP_SIG36)) begin // R6
					if (a_to_b)
						shadow_reg[35:18] <= chain_reg[35:18]; // R1
					else
						shadow_reg[17:0] <= chain_reg[17:0]; // R1
				end
				default: ;
				endcase
			end
		end
	end

	// pin drivers follow the shadow latches, re-timed by one clk
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			a_pin_out <= 18'h00000;
			b_pin_out <= 18'h00000;
			a_pin_oe_n <= 18'h3FFFF;
			b_pin_oe_n <= 18'h3FFFF;
		end else begin
			a_pin_out <= shadow_reg[17:0]; // R12
			b_pin_out <= shadow_reg[35:18]; // R12
			// oe cells gate each byte even during pattern runs
			if (test_drive) begin
				a_pin_oe_n <= {{9{shadow_reg[`CELL_OE2_BA]}},
					{9{shadow_reg[`CELL_OE1_BA]}}}; // R20
				b_pin_oe_n <= {{9{shadow_reg[`CELL_OE2_AB]}},
					{9{shadow_reg[`CELL_OE1_AB]}}}; // R20
			end else begin
				a_pin_oe_n <= 18'h3FFFF;
				b_pin_oe_n <= 18'h3FFFF;
			end
		end
	end

	// register port; read data stands one cycle only
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			run_en_reg <= `CTRL_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			if (reg_wr && (reg_addr == `REG_CTRL_OFS))
				run_en_reg <= reg_wdata[`CTRL_RUN_EN_BIT];
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
				`REG_CTRL_OFS: reg_rdata <= {31'h00000000, run_en_reg};
				`REG_STATUS_OFS: reg_rdata <= {22'h000000, running,
					a_to_b, dir_ok, test_ctl_reg, tap_reg};
				`REG_SIG_OFS: reg_rdata <= {14'h0000, a_to_b ?
					chain_reg[17:0] : chain_reg[35:18]};
				default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

//--- hw/bscan_engine_consts.vh
// constants for the boundary-scan pattern engine
`ifndef BSCAN_ENGINE_CONSTS_VH
`define BSCAN_ENGINE_CONSTS_VH

// register offsets on the plain register port (byte addresses)
`define REG_CTRL_OFS 4'h0
`define REG_STATUS_OFS 4'h4
`define REG_SIG_OFS 4'h8
// control register fields and reset value
`define CTRL_RUN_EN_BIT 0
`define CTRL_RESET 1'b1
// status register fields
`define STAT_TAP_LSB 0
`define STAT_MODE_LSB 4
`define STAT_DIR_OK_BIT 7
`define STAT_A_TO_B_BIT 8
`define STAT_RUNNING_BIT 9

// instruction register
`define IR_LEN 8
`define IR_CAPTURE 8'h81
`define IR_BYPASS 8'hFF
`define IR_CTRL_SCAN_N 8'h8E
`define IR_CTRL_SCAN_T 8'h0F
`define IR_BOUNDARY_SCAN 8'h00
`define IR_BOUNDARY_READ 8'h87
`define IR_BOUNDARY_RUN 8'h09

// boundary chain layout
`define CHAIN_LEN 48
`define CELL_OE1_AB 47
`define CELL_OE2_AB 46
`define CELL_OE1_BA 45
`define CELL_OE2_BA 44
`define TCTL_LEN 3
`define TCTL_RESET 3'h0

// feedback tap masks
`define TAPS36 36'h800000801
`define TAPS18 18'h20041

// synchroniser depth for pin inputs
`define SYNC_STAGES 2

`endif

//--- test/tap_host_model.sv
// host model that drives the test access port
`timescale 1ns/1ns
module tap_host_model (
	// tap wires
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// tck rests low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tms/tdi move just after the fall, tdo read just before the rise
	task automatic step(input logic m, input logic dv, output logic o);
		tms = m;
		tdi = dv;
		#62 o = tdo;
		tck = 1'b1;
		#63 tck = 1'b0;
	endtask
	// five ones reach reset, a zero leaves it for idle
	task automatic tlr();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
	// one scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input logic [47:0] v, input int n,
		output logic [47:0] q);
		logic o;
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		q = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], o);
			q[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

//--- test/boundary_scan_pattern_engine_assertions.sv
// concurrent checks on the pattern engine ports
`timescale 1ns/1ns
module bscan_engine_checker (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// test access port
	input wire tck,
	input wire tdo,
	input wire tdo_oe_n,
	// pins
	input wire [17:0] a_pin_out,
	input wire [17:0] a_pin_oe_n,
	input wire [17:0] b_pin_out,
	// register port
	input wire [3:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// tck low now and one sample ago
	sequence tck_low_s;
		!tck && !$past(tck);
	endsequence
	// no tck edge and no write for eight samples
	sequence quiet_s;
		($stable(tck) && !reg_wr)[*8];
	endsequence
	tdo_on_fall_a: assert property ($changed(tdo) |-> tck_low_s)
		else $error("tdo moved while tck high");
	pin_on_fall_a: assert property
		($changed(b_pin_out) || $changed(a_pin_out) |-> tck_low_s)
		else $error("pin value moved while tck high");
	oe_on_fall_a: assert property ($changed(tdo_oe_n) |-> tck_low_s)
		else $error("tdo enable moved while tck high");
	pin_once_a: assert property
		($changed(b_pin_out) |=> $stable(b_pin_out)[*8])
		else $error("pin value moved twice in one tck phase");
	quiet_hold_a: assert property (quiet_s |-> $stable(tdo) &&
		$stable(a_pin_out) && $stable(b_pin_out))
		else $error("outputs moved with tck idle");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	unmapped_zero_a: assert property
		(reg_rd && reg_addr == 4'hC |=> reg_rdata == 32'h0)
		else $error("unmapped read gave data");
	oe_halves_a: assert property (a_pin_oe_n[8:0] == {9{a_pin_oe_n[0]}} &&
		a_pin_oe_n[17:9] == {9{a_pin_oe_n[9]}})
		else $error("a pin enables split inside a byte");
endmodule
bind boundary_scan_pattern_engine bscan_engine_checker i_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tdo(tdo),
	.tdo_oe_n(tdo_oe_n), .a_pin_out(a_pin_out), .a_pin_oe_n(a_pin_oe_n),
	.b_pin_out(b_pin_out), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

//--- test/boundary_scan_pattern_engine_tb.sv
// self-checking bench for the boundary-scan pattern engine
`timescale 1ns/1ns
module boundary_scan_pattern_engine_tb;
	logic clk_sys = 1'b0;
	logic rst_n, tck, tms, tdi, tdo, tdo_oe_n, reg_wr, reg_rd;
	logic [17:0] a_pin_in, a_pin_out, a_pin_oe_n;
	logic [17:0] b_pin_in, b_pin_out, b_pin_oe_n;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [47:0] q;
	int n_fail = 0;
	int n_compared = 0;
	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;
	boundary_scan_pattern_engine i_boundary_scan_pattern_engine (
		.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n), .a_pin_in(a_pin_in),
		.a_pin_out(a_pin_out), .a_pin_oe_n(a_pin_oe_n), .b_pin_in(b_pin_in),
		.b_pin_out(b_pin_out), .b_pin_oe_n(b_pin_oe_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	tap_host_model i_tap_host_model (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo));
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask
	// control code, seed through boundary scan, then the run instruction
	task automatic setup(input logic [2:0] op, input logic [47:0] seed);
		i_tap_host_model.scan(1'b1, 48'h8E, 8, q);
		i_tap_host_model.scan(1'b0, 48'(op), 3, q);
		i_tap_host_model.scan(1'b1, 48'h00, 8, q);
		i_tap_host_model.scan(1'b0, seed, 48, q);
		i_tap_host_model.scan(1'b1, 48'h09, 8, q);
		rd(4'h4, d);
		check(48'(d[6:4]), 48'(op));
	endtask
	// k tck rises in idle, then let the pin pipeline settle
	task automatic run(input int k);
		logic b;
		repeat (k) i_tap_host_model.step(1'b0, 1'b0, b);
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// a full run is near 120 us; allow well over that before giving up
	initial begin
		#200000;
		n_fail++;
		close_out();
	end
	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		a_pin_in = 18'h0;
		b_pin_in = 18'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(4'h0, d);
		check(48'(d), 48'h1);
		rd(4'hC, d);
		check(48'(d), 48'h0);
		check(48'(b_pin_oe_n), 48'h3FFFF);
		i_tap_host_model.tlr();
		i_tap_host_model.scan(1'b1, 48'hFF, 8, q);
		check(48'(q[7:0]), 48'h81);
		i_tap_host_model.scan(1'b0, 48'h5, 3, q);
		check(48'(q[2:0]), 48'h2);
		// a-to-b count wraps through zero
		setup(3'b111, {12'h300, 18'h3FFFE, 18'h0});
		run(3);
		check(48'(b_pin_out), 48'h1);
		check(48'(b_pin_oe_n), 48'h0);
		// all-zero generator stays put
		setup(3'b101, {12'h300, 36'h0});
		run(4);
		check(48'(b_pin_out), 48'h0);
		setup(3'b001, {12'h300, 18'h1, 18'h0});
		run(1);
		check(48'(b_pin_out), 48'h2);
		@(posedge clk_sys);
		a_pin_in <= 18'h12345;
		setup(3'b010, {12'h300, 18'h2AAAA, 18'h0});
		run(3);
		check(48'(b_pin_out), 48'h2AAAA);
		rd(4'h8, d);
		check(48'(d[17:0] != 18'h0), 48'h1);
		setup(3'b011, {12'h300, 18'h1, 18'h0});
		run(1);
		check(48'(b_pin_out), 48'h3);
		rd(4'h8, d);
		check(48'(d[17:0]), 48'h12345);
		// toggle inverts the outputs and samples the inputs
		setup(3'b100, {12'h300, 18'h0F0F0, 18'h0});
		run(1);
		check(48'(b_pin_out), 48'h30F0F);
		rd(4'h8, d);
		check(48'(d[17:0]), 48'h12345);
		// reverse direction counts on the a side
		setup(3'b111, {12'hC00, 18'h0, 18'h3FFFF});
		run(2);
		check(48'(a_pin_out), 48'h1);
		check(48'(a_pin_oe_n), 48'h0);
		// both directions enabled behaves as bypass, pins released
		setup(3'b111, 48'h0);
		run(2);
		check(48'({a_pin_oe_n, b_pin_oe_n}), 48'hFFFFFFFFF);
		rd(4'h4, d);
		check(48'(d[7]), 48'h0);
		// run enable cleared: pattern must not step
		wr(4'h0, 32'h0);
		setup(3'b111, {12'h300, 18'h5, 18'h0});
		run(3);
		check(48'(b_pin_out), 48'h5);
		wr(4'h0, 32'h1);
		i_tap_host_model.tlr();
		check(48'(tdo_oe_n), 48'h1);
		close_out();
	end
endmodule
